// file: vsd_pkg.sv
// Constants and types shared by the vertical sync divider design.
package vsd_pkg;

   localparam int CLK_NS = 40;
   localparam int VS_MIN_NS = 8000;
   localparam int VS_MIN_CYC = (VS_MIN_NS + CLK_NS - 1) / CLK_NS;
   localparam int VS_HOLD_NS = 24000;
   localparam int VS_HOLD_CYC = (VS_HOLD_NS + CLK_NS - 1) / CLK_NS;

   localparam int PIN_W = 6;
   localparam int PIN_HLINE = 0;
   localparam int PIN_HSYNC = 1;
   localparam int PIN_GATE = 2;
   localparam int PIN_VSYNC = 3;
   localparam int PIN_STRONG = 4;
   localparam int PIN_EXT = 5;

   localparam logic [10:0] LINE_CYC_MAX = 11'h7FF;
   localparam logic [7:0] VS_MIN = 8'(VS_MIN_CYC);
   localparam logic [9:0] VS_HOLD = 10'(VS_HOLD_CYC);

   localparam logic [9:0] WIDE_LO = 10'h1E8;
   localparam logic [9:0] WIDE_HI = 10'h2D2;
   localparam logic [9:0] N60_LO = 10'h20A;
   localparam logic [9:0] N60_HI = 10'h210;
   localparam logic [9:0] N50_LO = 10'h26E;
   localparam logic [9:0] N50_HI = 10'h274;
   localparam logic [9:0] RATE_SPLIT = 10'h240;
   localparam logic [9:0] ATF_END_50 = 10'h00A;
   localparam logic [9:0] ATF_END_60 = 10'h00C;
   localparam logic [9:0] BLANK_END_60 = 10'h022;
   localparam logic [9:0] BLANK_END_50 = 10'h02A;
   localparam logic [9:0] EQ_START_60 = 10'h205;
   localparam logic [9:0] EQ_START_50 = 10'h269;

   localparam logic [3:0] CONF_MAX = 4'hF;
   localparam logic [3:0] CONF_LOW = 4'h6;
   localparam logic [2:0] COIN_MAX = 3'h7;
   localparam logic [2:0] COIN_ON = 3'h4;

   typedef enum logic {
      MODE_WIDE = 1'b0,
      MODE_NARROW = 1'b1
   } mode_t;

   typedef enum logic [2:0] {
      TC_FAST = 3'b000,
      TC_MODERATE = 3'b001,
      TC_SLOW = 3'b010,
      TC_DOUBLE_FAST = 3'b011,
      TC_EXTERNAL = 3'b100
   } tc_t;

endpackage

// file: pin_sync.sv
// Two-stage synchroniser for a group of asynchronous pin inputs.
`timescale 1ns/1ps
`default_nettype none
module pin_sync #(
   parameter int WIDTH = 6
) (
   input wire logic sys_clk,
   input wire logic reset,
   input wire logic [WIDTH-1:0] pins,
   output logic [WIDTH-1:0] pins_sync
);

   logic [WIDTH-1:0] stage1;

   // The first stage feeds only the second one, to keep metastability contained.
   always_ff @(posedge sys_clk) begin
      if (reset) begin
         stage1 <= '0;
         pins_sync <= '0;
      end else begin
         stage1 <= pins;
         pins_sync <= stage1;
      end
   end

endmodule
`default_nettype wire

// file: vertical_sync_divider.sv
// Line and field timing: phase detector mode, vertical divider, blanking and anti-topflutter.
//
// How it works
// - Strong signal: detector ungated, fast constant in retrace, moderate constant in scan.
// - Weak signal: doubled constants, detector gated while oscillator is synchronised.
// - Weak and unsynchronised: moderate scan constant during scan and retrace.
// - Vertical sync detected even from 10 us pulses spaced 22 us apart.
// - Divider advances twice per line, from a doubled line clock.
// - Trigger before count 576 selects 60 Hz, otherwise 50 Hz.
// - Confidence counter up on sync inside window, down on sync outside.
// - Wide mode accepts a vertical reset at counts 488 through 722.
// - Wide mode when locking, ratio off narrow limits, or confidence below 6.
// - Sync still present after anti-topflutter ends forces wide mode, non-standard.
// - Non-standard sync decouples ramp retrace from horizontal oscillator; normal keeps it.
// - Narrow mode accepts 522-528 at 60 Hz and 622-628 at 50 Hz.
// - Confidence reaching 15 switches wide mode to narrow mode.
// - Narrow mode missing sync resets divider at window end, confidence down one.
// - Anti-topflutter from reset (wide) or first equaliser (narrow) to 10/12.
// - Vertical blanking from reset to count 34 (60 Hz) or 42 (50 Hz).
// - Sandcastle vertical blanking is anti-topflutter OR blanking pulse.
// - External video: AGC ungated, AFC on, no muting, external detector constant.
// - In-sync comes from coincidence of separated sync and internal gating pulse.
`timescale 1ns/1ps
`default_nettype none
module vertical_sync_divider (
   input wire logic sys_clk,
   input wire logic reset,
   input wire logic hosc_line,
   input wire logic hsync_sep,
   input wire logic hgate_pulse,
   input wire logic vsync_sep,
   input wire logic strong_signal,
   input wire logic ext_video_sel,
   output logic vert_reset,
   output logic vblank_out,
   output logic atf_inhibit,
   output logic field_60hz,
   output logic narrow_mode,
   output logic ramp_coupled,
   output logic in_sync,
   output vsd_pkg::tc_t pd_tc,
   output logic pd_gated,
   output logic agc_gate_en,
   output logic afc_en,
   output logic mute_en
);

   function automatic logic in_range(input logic [9:0] v, input logic [9:0] lo, input logic [9:0] hi);
      in_range = (v >= lo) && (v <= hi);
   endfunction

   ////////////////////////////////////////////////////////////////////////////
   // Pin synchronisation.

   logic [vsd_pkg::PIN_W-1:0] pins_s;
   wire logic hline_s = pins_s[vsd_pkg::PIN_HLINE];
   wire logic hsync_s = pins_s[vsd_pkg::PIN_HSYNC];
   wire logic gate_s = pins_s[vsd_pkg::PIN_GATE];
   wire logic vsync_s = pins_s[vsd_pkg::PIN_VSYNC];
   wire logic strong_s = pins_s[vsd_pkg::PIN_STRONG];
   wire logic ext_s = pins_s[vsd_pkg::PIN_EXT];

   pin_sync #(.WIDTH(vsd_pkg::PIN_W)) u_sync (
      .sys_clk(sys_clk),
      .reset(reset),
      .pins({ext_video_sel, strong_signal, vsync_sep, hgate_pulse, hsync_sep, hosc_line}),
      .pins_sync(pins_s)
   );

   ////////////////////////////////////////////////////////////////////////////
   // Line-rate doubler: a tick at each line start and at the measured mid-line.

   logic hline_d;
   logic [10:0] line_cyc;
   logic [10:0] half_per;
   wire logic line_edge = hline_s & ~hline_d;
   wire logic mid_tick = (line_cyc == half_per) && (half_per != 11'h000) && !line_edge;
   wire logic tick = line_edge | mid_tick;

   always_ff @(posedge sys_clk) begin
      if (reset) begin
         hline_d <= 1'b0;
         line_cyc <= 11'h000;
         half_per <= 11'h000;
      end else begin
         hline_d <= hline_s;
         if (line_edge) begin
            line_cyc <= 11'h000;
            half_per <= {1'b0, line_cyc[10:1]};
         end else if (line_cyc != vsd_pkg::LINE_CYC_MAX) begin
            line_cyc <= line_cyc + 11'h001;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Coincidence detector for the in-sync indication.

   logic coin_hit;
   logic [2:0] coin_cnt;
   wire logic coin_now = hsync_s & gate_s;
   wire logic line_hit = coin_hit | coin_now;
   assign in_sync = (coin_cnt >= vsd_pkg::COIN_ON);

   always_ff @(posedge sys_clk) begin
      if (reset) begin
         coin_hit <= 1'b0;
         coin_cnt <= 3'h0;
      end else begin
         coin_hit <= line_edge ? 1'b0 : line_hit;
         if (line_edge && line_hit && coin_cnt != vsd_pkg::COIN_MAX) begin
            coin_cnt <= coin_cnt + 3'h1;
         end else if (line_edge && !line_hit && coin_cnt != 3'h0) begin
            coin_cnt <= coin_cnt - 3'h1;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Vertical sync integrator. A pulse must stay high 8 us to qualify, which
   // rejects equalising and line pulses; the 24 us hold bridges the 12 us gaps
   // of narrow anti-copy pulses so they read as one field sync.

   logic [7:0] hi_run;
   logic [9:0] hold;
   logic vs_level_d;
   wire logic vs_qual = vsync_s && (hi_run == vsd_pkg::VS_MIN);
   wire logic vs_level = (hold != 10'h000);
   wire logic trigger = vs_level & ~vs_level_d;

   always_ff @(posedge sys_clk) begin
      if (reset) begin
         hi_run <= 8'h00;
         hold <= 10'h000;
         vs_level_d <= 1'b0;
      end else begin
         vs_level_d <= vs_level;
         if (!vsync_s) begin
            hi_run <= 8'h00;
         end else if (hi_run != vsd_pkg::VS_MIN) begin
            hi_run <= hi_run + 8'h01;
         end
         if (vs_qual) begin
            hold <= vsd_pkg::VS_HOLD;
         end else if (vs_level && !vsync_s) begin
            hold <= hold - 10'h001;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Divider, windows and confidence counter.

   vsd_pkg::mode_t mode;
   logic [9:0] count;
   logic [3:0] conf;
   logic nonstd;
   logic atf;
   logic blank;
   logic [3:0] next_conf;

   wire logic narrow = (mode == vsd_pkg::MODE_NARROW);
   wire logic [9:0] win_lo = !narrow ? vsd_pkg::WIDE_LO : field_60hz ? vsd_pkg::N60_LO : vsd_pkg::N50_LO;
   wire logic [9:0] win_hi = !narrow ? vsd_pkg::WIDE_HI : field_60hz ? vsd_pkg::N60_HI : vsd_pkg::N50_HI;
   wire logic in_win = in_range(count, win_lo, win_hi);
   wire logic narrow_ok = in_range(count, vsd_pkg::N60_LO, vsd_pkg::N60_HI)
                          | in_range(count, vsd_pkg::N50_LO, vsd_pkg::N50_HI);
   wire logic accept = trigger & in_win;
   wire logic miss_end = tick && (count == win_hi) && !accept;
   wire logic div_reset = accept | miss_end;
   wire logic [9:0] atf_end = field_60hz ? vsd_pkg::ATF_END_60 : vsd_pkg::ATF_END_50;
   wire logic [9:0] blank_end = field_60hz ? vsd_pkg::BLANK_END_60 : vsd_pkg::BLANK_END_50;
   wire logic [9:0] eq_start = field_60hz ? vsd_pkg::EQ_START_60 : vsd_pkg::EQ_START_50;
   wire logic at_atf_end = tick && (count + 10'h001 == atf_end) && !div_reset;
   wire logic nonstd_hit = at_atf_end & vs_level;
   wire logic ratio_off = accept & ~narrow & ~narrow_ok;
   wire logic conf_clear = ~in_sync | ratio_off | nonstd_hit;
   wire logic conf_up = accept;
   wire logic conf_dn = (trigger & ~in_win) | (miss_end & narrow);
   wire logic force_wide = ~in_sync | nonstd_hit | (narrow && conf < vsd_pkg::CONF_LOW);

   // Saturating counter: clearing beats counting, counting never wraps.
   always_comb begin
      next_conf = conf;
      if (conf_clear) begin
         next_conf = 4'h0;
      end else if (conf_up && conf != vsd_pkg::CONF_MAX) begin
         next_conf = conf + 4'h1;
      end else if (conf_dn && !conf_up && conf != 4'h0) begin
         next_conf = conf - 4'h1;
      end
   end

   always_ff @(posedge sys_clk) begin
      if (reset) begin
         mode <= vsd_pkg::MODE_WIDE;
         conf <= 4'h0;
         field_60hz <= 1'b0;
      end else begin
         conf <= next_conf;
         if (force_wide) begin
            mode <= vsd_pkg::MODE_WIDE;
         end else if (!narrow && conf == vsd_pkg::CONF_MAX) begin
            mode <= vsd_pkg::MODE_NARROW;
         end
         if (accept) begin
            field_60hz <= (count < vsd_pkg::RATE_SPLIT);
         end
      end
   end

   always_ff @(posedge sys_clk) begin
      if (reset) begin
         count <= 10'h000;
      end else if (div_reset) begin
         count <= 10'h000;
      end else if (tick) begin
         count <= count + 10'h001;
      end
   end

   // A wide sync still standing when the anti-topflutter ends marks the source
   // non-standard until a field passes with the sync gone by that point.
   always_ff @(posedge sys_clk) begin
      if (reset) begin
         nonstd <= 1'b0;
      end else if (at_atf_end) begin
         nonstd <= vs_level;
      end
   end

   always_ff @(posedge sys_clk) begin
      if (reset) begin
         atf <= 1'b0;
         blank <= 1'b0;
      end else begin
         if ((div_reset && !narrow) || (narrow && tick && count + 10'h001 == eq_start)) begin
            atf <= 1'b1;
         end else if (at_atf_end) begin
            atf <= 1'b0;
         end
         if (div_reset) begin
            blank <= 1'b1;
         end else if (tick && count + 10'h001 == blank_end) begin
            blank <= 1'b0;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Registered outputs.

   vsd_pkg::tc_t next_tc;
   wire logic retrace = blank | atf;

   always_comb begin
      if (ext_s) begin
         next_tc = vsd_pkg::TC_EXTERNAL;
      end else if (strong_s) begin
         next_tc = retrace ? vsd_pkg::TC_FAST : vsd_pkg::TC_MODERATE;
      end else if (in_sync) begin
         next_tc = retrace ? vsd_pkg::TC_DOUBLE_FAST : vsd_pkg::TC_SLOW;
      end else begin
         next_tc = vsd_pkg::TC_MODERATE;
      end
   end

   always_ff @(posedge sys_clk) begin
      if (reset) begin
         pd_tc <= vsd_pkg::TC_MODERATE;
         pd_gated <= 1'b0;
         agc_gate_en <= 1'b1;
         afc_en <= 1'b0;
         mute_en <= 1'b1;
         vert_reset <= 1'b0;
         vblank_out <= 1'b0;
         atf_inhibit <= 1'b0;
         narrow_mode <= 1'b0;
         ramp_coupled <= 1'b1;
      end else begin
         pd_tc <= next_tc;
         pd_gated <= !ext_s && !strong_s && in_sync;
         agc_gate_en <= !ext_s;
         afc_en <= ext_s || in_sync;
         mute_en <= !ext_s && !in_sync;
         vert_reset <= div_reset;
         vblank_out <= atf | blank;
         atf_inhibit <= atf;
         narrow_mode <= narrow;
         ramp_coupled <= !nonstd;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Checks.

   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (reset);

   sequence seq_atf_ends;
      atf && at_atf_end;
   endsequence

   sequence seq_narrow_miss;
      narrow && miss_end && !trigger && conf > 4'h0 && !conf_clear;
   endsequence

   chk_strong_ungated: assert property (strong_s && !ext_s |=> !pd_gated && (pd_tc == vsd_pkg::TC_FAST
      || pd_tc == vsd_pkg::TC_MODERATE)) else $error("strong signal detector mode wrong");
   chk_weak_gated: assert property (!strong_s && !ext_s && in_sync |=> pd_gated
      && pd_tc != vsd_pkg::TC_MODERATE) else $error("weak synced detector mode wrong");
   chk_weak_nosync_tc: assert property (!strong_s && !ext_s && !in_sync |=> !pd_gated
      && pd_tc == vsd_pkg::TC_MODERATE) else $error("weak unsynced constant wrong");
   chk_tick_advance: assert property (tick && !div_reset |=> count == $past(count) + 10'h001)
      else $error("divider did not advance on tick");
   chk_rate_choice: assert property (accept |=> field_60hz == ($past(count) < vsd_pkg::RATE_SPLIT))
      else $error("field rate choice wrong");
   chk_wide_accept: assert property (!narrow && trigger && count >= 10'h1E8 && count <= 10'h2D2
      |=> count == 10'h000) else $error("wide window reset missed");
   chk_narrow_exit: assert property (narrow && conf < vsd_pkg::CONF_LOW |=> !narrow)
      else $error("narrow mode kept at low confidence");
   chk_narrow_entry: assert property (!narrow && conf == vsd_pkg::CONF_MAX && !force_wide |=> narrow)
      else $error("narrow mode not entered");
   chk_miss_decrement: assert property (seq_narrow_miss |=> count == 10'h000
      && conf == $past(conf) - 4'h1) else $error("missed sync handling wrong");
   chk_atf_end: assert property (seq_atf_ends |=> !atf ##1 !atf_inhibit)
      else $error("anti-topflutter did not end");
   chk_blank_start: assert property (div_reset |=> blank ##1 vblank_out)
      else $error("blanking did not start at reset");
   chk_conf_ceiling: assert property (conf == vsd_pkg::CONF_MAX && !conf_clear && !conf_dn
      |=> conf == vsd_pkg::CONF_MAX) else $error("confidence wrapped");
   chk_ext_mode: assert property (ext_s |=> !agc_gate_en && afc_en && !mute_en
      && pd_tc == vsd_pkg::TC_EXTERNAL) else $error("external video mode wrong");
   chk_ramp_decouple: assert property (nonstd_hit |=> nonstd ##1 !ramp_coupled)
      else $error("ramp not decoupled");

endmodule
`default_nettype wire

// file: sync_source.sv
// Behavioural sync separator that feeds line, gating and field sync pulses to the divider.
`timescale 1ns/1ps
`default_nettype none
module sync_source #(
   parameter int LINE_CYC = 160
) (
   input wire logic sys_clk,
   input wire logic restart,
   input wire logic [9:0] half_lines,
   input wire logic [1:0] vs_kind,
   input wire logic hs_shift,
   output var logic hosc_line = 1'b0,
   output var logic hsync_sep = 1'b0,
   output var logic hgate_pulse = 1'b0,
   output var logic vsync_sep = 1'b0
);
   localparam int VS_W = 210;
   int line_cnt = 0;
   int field_cnt = VS_W;
   int field_len;
   logic vs_next;

   assign field_len = int'(half_lines) * (LINE_CYC / 2);

   ////////////////////////////////////////////////////////////////////////////////
   // Copy-guard fields split the sync into 10 us bursts every 22 us; the divider must bridge the gaps.
   always_comb begin
      case (vs_kind)
         2'h0: vs_next = field_cnt < VS_W;
         2'h1: vs_next = field_cnt < 250 || (field_cnt >= 550 && field_cnt < 800) ||
            (field_cnt >= 1100 && field_cnt < 1350);
         default: vs_next = 1'b0;
      endcase
   end

   // A restart puts the field phase just past its pulse, so the first trigger lands one full field later.
   always @(posedge sys_clk) begin
      line_cnt <= (line_cnt == LINE_CYC - 1) ? 0 : line_cnt + 1;
      if (restart) begin
         field_cnt <= VS_W;
      end else if (field_cnt >= field_len - 1) begin
         field_cnt <= 0;
      end else begin
         field_cnt <= field_cnt + 1;
      end
      hosc_line <= line_cnt < 12;
      hgate_pulse <= line_cnt < 16;
      hsync_sep <= hs_shift ? (line_cnt >= 60 && line_cnt < 72) : (line_cnt >= 2 && line_cnt < 14);
      vsync_sep <= vs_next;
   end
endmodule
`default_nettype wire

// file: tb_vertical_sync_divider.sv
// Self-checking bench for the vertical sync divider.
`timescale 1ns/1ps
`default_nettype none
module tb_vertical_sync_divider;
   localparam int HL = 80;
   logic sys_clk = 1'b0;
   logic reset = 1'b1;
   logic strong_signal = 1'b1;
   logic ext_video_sel = 1'b0;
   logic hs_shift = 1'b0;
   logic [9:0] half_lines = 10'h271;
   logic [1:0] vs_kind = 2'h0;
   logic hosc_line, hsync_sep, hgate_pulse, vsync_sep;
   logic vert_reset, vblank_out, atf_inhibit, field_60hz, narrow_mode, ramp_coupled, in_sync;
   logic pd_gated, agc_gate_en, afc_en, mute_en;
   vsd_pkg::tc_t pd_tc;
   int bad_count = 0;
   int samples_checked = 0;
   int cycles = 0;
   int last_vr = 0;
   int n;
   int k;
   int la;
   int lb;

   sync_source #(.LINE_CYC(2 * HL)) i_sync_source (.sys_clk, .restart(reset), .half_lines, .vs_kind,
      .hs_shift, .hosc_line, .hsync_sep, .hgate_pulse, .vsync_sep);
   vertical_sync_divider i_vertical_sync_divider (.sys_clk, .reset, .hosc_line, .hsync_sep, .hgate_pulse,
      .vsync_sep, .strong_signal, .ext_video_sel, .vert_reset, .vblank_out, .atf_inhibit, .field_60hz,
      .narrow_mode, .ramp_coupled, .in_sync, .pd_tc, .pd_gated, .agc_gate_en, .afc_en, .mute_en);

   always #20 sys_clk = ~sys_clk;

   ////////////////////////////////////////////////////////////////////////////////
   task automatic finish_test();
      $display("Checks %0d, mismatches %0d", samples_checked, bad_count);
      if (bad_count == 0 && samples_checked > 0) begin
         $display("SIMULATION PASSED");
      end else begin
         $display("SIMULATION FAILED");
      end
      $finish;
   endtask

   always @(posedge sys_clk) begin
      cycles <= cycles + 1;
      if (cycles == 2500000) begin
         bad_count = bad_count + 1;
         finish_test();
      end
   end

   task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
      samples_checked++;
      if (seen !== exp) begin
         $display("ERROR %s expected %0h seen %0h", name, exp, seen);
         bad_count++;
      end
   endtask

   // Half-line phase is free against the divider reset, so a pulse may lose up to one count.
   task automatic chk_len(input string name, input int len, input int cnt);
      check(name, 32'(len >= (cnt - 1) * HL - HL / 4 && len <= cnt * HL + 8), 32'h1);
   endtask

   task automatic chk_iv(input string name, input int cnt);
      check(name, 32'(n >= cnt * HL - 4 && n <= cnt * HL + 4), 32'h1);
   endtask

   task automatic wait_vr(input int lim);
      int w;
      w = 0;
      do begin
         @(negedge sys_clk);
         w++;
      end while (vert_reset !== 1'b1 && w < lim);
      check("vert_reset seen", 32'(vert_reset), 32'h1);
      n = cycles - last_vr;
      last_vr = cycles;
   endtask

   function automatic logic sel(input int w);
      return (w == 0) ? vblank_out : atf_inhibit;
   endfunction

   task automatic pulse_len(input int w, output int len);
      int t;
      t = 0;
      len = 0;
      while (sel(w) !== 1'b1 && t < 50000) begin
         @(negedge sys_clk);
         t++;
      end
      while (sel(w) === 1'b1 && len < 50000) begin
         @(negedge sys_clk);
         len++;
      end
   endtask

   task automatic do_reset();
      @(posedge sys_clk);
      reset <= 1'b1;
      repeat (20) @(posedge sys_clk);
      @(negedge sys_clk);
      check("reset outputs", 32'({vert_reset, vblank_out, atf_inhibit, field_60hz, narrow_mode, ramp_coupled,
         in_sync, pd_gated, agc_gate_en, afc_en, mute_en}), 32'h025);
      check("reset pd_tc", 32'(pd_tc), 32'(vsd_pkg::TC_MODERATE));
      @(posedge sys_clk);
      reset <= 1'b0;
   endtask

   ////////////////////////////////////////////////////////////////////////////////
   task automatic t_field(input int cnt, input logic rate, input int blank, input int atf);
      wait_vr(60000);
      chk_iv("field interval", cnt);
      fork
         pulse_len(0, lb);
         pulse_len(1, la);
      join
      check("rate flag", 32'(field_60hz), 32'(rate));
      chk_len("blank length", lb, blank);
      chk_len("atf length", la, atf);
   endtask

   task automatic t_detector();
      check("scan strong", 32'({pd_tc, pd_gated}), 32'h2);
      wait_vr(60000);
      repeat (4) @(negedge sys_clk);
      check("retrace strong", 32'({pd_tc, pd_gated}), 32'h0);
      @(posedge sys_clk);
      strong_signal <= 1'b0;
      wait_vr(60000);
      repeat (4) @(negedge sys_clk);
      check("retrace weak", 32'({pd_tc, pd_gated}), 32'h7);
      repeat (4000) @(negedge sys_clk);
      check("scan weak", 32'({pd_tc, pd_gated}), 32'h5);
      @(posedge sys_clk);
      strong_signal <= 1'b1;
   endtask

   task automatic t_copy();
      repeat (2000) @(negedge sys_clk);
      @(posedge sys_clk);
      vs_kind <= 2'h1;
      wait_vr(60000);
      chk_iv("copy interval", 525);
      repeat (1500) @(negedge sys_clk);
      check("copy mode", 32'({ramp_coupled, narrow_mode}), 32'h0);
      wait_vr(60000);
      chk_iv("copy interval next", 525);
      repeat (2000) @(negedge sys_clk);
      @(posedge sys_clk);
      vs_kind <= 2'h0;
      wait_vr(60000);
      repeat (1500) @(negedge sys_clk);
      check("normal coupling", 32'(ramp_coupled), 32'h1);
   endtask

   task automatic t_lock();
      do_reset();
      k = 0;
      while (narrow_mode !== 1'b1 && k < 30) begin
         wait_vr(60000);
         k++;
         repeat (2) @(negedge sys_clk);
      end
      check("fields to narrow", 32'(k), 32'h0F);
      wait_vr(60000);
      chk_iv("narrow interval", 525);
      repeat (4000) @(negedge sys_clk);
      pulse_len(0, lb);
      chk_len("narrow blank", lb, 42);
      wait_vr(60000);
      @(posedge sys_clk);
      vs_kind <= 2'h2;
      wait_vr(60000);
      // A missed sync resets at the close of count 528, so the interval always runs past 528 half-lines.
      check("missed sync reset", 32'(n > 528 * HL && n <= 529 * HL), 32'h1);
      repeat (2) @(negedge sys_clk);
      check("narrow after miss", 32'(narrow_mode), 32'h1);
      k = 1;
      while (narrow_mode === 1'b1 && k < 20) begin
         wait_vr(60000);
         k++;
         repeat (2) @(negedge sys_clk);
      end
      check("misses to wide", 32'(k), 32'h0A);
   endtask

   task automatic t_phase();
      @(posedge sys_clk);
      strong_signal <= 1'b0;
      hs_shift <= 1'b1;
      repeat (1600) @(negedge sys_clk);
      check("lost sync", 32'({in_sync, afc_en, mute_en, narrow_mode}), 32'h2);
      check("scan unsync", 32'({pd_tc, pd_gated}), 32'h2);
      wait_vr(60000);
      repeat (4) @(negedge sys_clk);
      check("retrace unsync", 32'({pd_tc, pd_gated}), 32'h2);
      @(posedge sys_clk);
      hs_shift <= 1'b0;
      repeat (1600) @(negedge sys_clk);
      check("regained sync", 32'({in_sync, afc_en, mute_en}), 32'h6);
      @(posedge sys_clk);
      ext_video_sel <= 1'b1;
      repeat (8) @(negedge sys_clk);
      check("external", 32'({pd_tc, pd_gated, agc_gate_en, afc_en, mute_en}), 32'h42);
   endtask

   initial begin
      do_reset();
      wait_vr(60000);
      t_field(625, 1'b0, 42, 10);
      t_detector();
      wait_vr(60000);
      @(posedge sys_clk);
      half_lines <= 10'h20D;
      t_field(525, 1'b1, 34, 12);
      t_copy();
      t_lock();
      t_phase();
      finish_test();
   end
endmodule
`default_nettype wire
